/* File: tc_pkg.sv */
// Purpose: Shared constants of the three-channel 32-bit timer core
// Assumes: APB with 8-bit byte address, 32-bit data, one word per register
// Notes:   Channel n sits at n*0x40, block registers from 0xC0
package tc_pkg;

  localparam int NCH = 3;

  // Register byte offsets inside one channel window
  localparam logic [7:0] OFF_CCR = 8'h00;
  localparam logic [7:0] OFF_CMR = 8'h04;
  localparam logic [7:0] OFF_CV  = 8'h10;
  localparam logic [7:0] OFF_CPB = 8'h18;
  localparam logic [7:0] OFF_CMP = 8'h1C;
  localparam logic [7:0] OFF_SR  = 8'h20;
  // Block register offsets, decoded when the channel index is 3
  localparam logic [7:0] OFF_BCR = 8'h00;
  localparam logic [7:0] OFF_BMR = 8'h04;
  localparam logic [1:0] BLK_IDX = 2'h3;

  // channel_control_reg bits
  localparam int CCR_EN    = 0;
  localparam int CCR_DIS   = 1;
  localparam int CCR_SWTRG = 2;
  // block_control_reg bit
  localparam int BCR_SYNC  = 0;

  // channel_mode_reg fields
  localparam int CMR_INVC  = 3;
  localparam int CMR_GATE  = 4;
  localparam int CMR_STOP  = 6;
  localparam int CMR_DIS   = 7;
  localparam int CMR_TSRCB = 10;
  localparam int CMR_ETEN  = 12;
  localparam int CMR_CTRG  = 14;
  localparam int CMR_WAVE  = 15;

  // channel_status_reg bits
  localparam int SR_OVF = 0;
  localparam int SR_CMT = 4;
  localparam int SR_BLD = 6;
  localparam int SR_RUN = 16;

  // clock_source_select codes
  localparam logic [2:0] CS_DIV2   = 3'h0;
  localparam logic [2:0] CS_DIV8   = 3'h1;
  localparam logic [2:0] CS_DIV32  = 3'h2;
  localparam logic [2:0] CS_DIV128 = 3'h3;
  localparam logic [2:0] CS_SLOW   = 3'h4;
  localparam logic [2:0] CS_EXT0   = 3'h5;
  localparam logic [2:0] CS_EXT1   = 3'h6;
  localparam logic [2:0] CS_EXT2   = 3'h7;

  // Prescaler bits that toggle at master_clock / 2, 8, 32, 128
  localparam int PRE_DIV2   = 0;
  localparam int PRE_DIV8   = 2;
  localparam int PRE_DIV32  = 4;
  localparam int PRE_DIV128 = 6;

  localparam logic [31:0] CNT_MAX = 32'hFFFFFFFF;

endpackage

/* File: timer_block.sv */
// Purpose: Three-channel 32-bit timer core with APB register access
// Assumes: pclk is master_clock at 100 MHz; pins are asynchronous
// Notes:   Pins pass two flops; APB answers after one wait state
// Operation
// RULE1: three independent channels, each own interrupt line
// RULE2: block control write starts all channels
// RULE3: counter adds one per counting edge
// RULE4: wrap from all-ones sets overflow flag
// RULE5: counter value read is live
// RULE6: trigger zeroes counter at next edge
// RULE7: block mode chains clocks to io_line_a
// RULE8: clock source from three external, five internal
// RULE9: clock_invert counts on falling edges
// RULE10: gate input passes clock only while high
// RULE11: external clock slower than pclk by 2.5
// RULE12: enable and disable commands control clock
// RULE13: b load or c match auto disable
// RULE14: disabled clock ignores start and stop
// RULE15: running status reads set while enabled
// RULE16: a trigger starts the clock while it is enabled
// RULE17: b load or c match stops clock
// RULE18: start and stop only while enabled
// RULE19: mode bit selects capture or waveform
// RULE20: capture mode drives neither io line
// RULE21: waveform drives a, b unless trigger
// RULE22: trigger acted on at next edge
// RULE23: reset leaves counters zero, clocks off
`timescale 1ns/10ps
module timer_block
  import tc_pkg::*;
(
  // APB clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins, asynchronous to pclk
  input  wire logic        slow_clock,
  input  wire logic [2:0]  ext_clock_pins,
  input  wire logic [2:0]  io_line_a_in,
  input  wire logic [2:0]  io_line_b_in,
  // Pin drivers
  output logic      [2:0]  io_line_a_out,
  output logic      [2:0]  io_line_a_oe,
  output logic      [2:0]  io_line_b_out,
  output logic      [2:0]  io_line_b_oe,
  // Per-channel interrupt lines
  output logic      [2:0]  channel_irq
);

  typedef struct packed {
    logic [6:0]        pre;
    logic              sy1_slow;
    logic              sy2_slow;
    logic [2:0]        sy1_clk;
    logic [2:0]        sy2_clk;
    logic [2:0]        sy1_a;
    logic [2:0]        sy2_a;
    logic [2:0]        sy1_b;
    logic [2:0]        sy2_b;
    logic [2:0]        prev_a;
    logic [2:0]        prev_b;
    logic [2:0]        prev_lvl;
    logic [2:0]        bmr;
    logic [2:0][15:0]  cmr;
    logic [2:0][31:0]  cnt;
    logic [2:0][31:0]  capb;
    logic [2:0][31:0]  cmpc;
    logic [2:0]        en;
    logic [2:0]        run;
    logic [2:0]        pend;
    logic [2:0]        ovf;
    logic [2:0]        cmt;
    logic [2:0]        bld;
    logic [2:0]        a_out;
    logic [2:0]        a_oe;
    logic [2:0]        b_out;
    logic [2:0]        b_oe;
    logic [2:0]        irq;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
  } state_t;

  state_t      s;
  state_t      next_s;
  logic [2:0]  tick;
  logic [2:0]  trig;
  logic [2:0]  chit;
  logic [2:0]  bload;
  logic [2:0]  xc;
  logic [2:0]  a_lvl;
  logic        acc;
  logic        wr;
  logic        rd;
  logic        blk;
  logic [1:0]  ci;
  logic [7:0]  off;
  logic [31:0] rv;
  logic        hit;

  // Decode and combine all next-state terms
  always_comb begin
    logic       lvl;
    logic       gate;
    logic       wave;
    logic       stp;
    logic       dis;
    logic       a_rise;
    logic       b_rise;
    logic       ext;
    logic       sr_rd;
    logic       ccr_wr;
    logic [1:0] gsel;
    lvl    = 1'b0;
    gate   = 1'b0;
    wave   = 1'b0;
    stp    = 1'b0;
    dis    = 1'b0;
    a_rise = 1'b0;
    b_rise = 1'b0;
    ext    = 1'b0;
    sr_rd  = 1'b0;
    ccr_wr = 1'b0;
    gsel   = 2'h0;
    next_s = s;
    // Access completes at the edge where pready is already high
    acc = psel & penable & s.pready;
    wr  = acc & pwrite;
    rd  = acc & ~pwrite;
    blk = (paddr[7:6] == BLK_IDX);
    ci  = blk ? 2'h0 : paddr[7:6];
    off = {2'h0, paddr[5:0]};

    // Pin synchronisers; first stage feeds only the second
    next_s.sy1_slow = slow_clock;
    next_s.sy2_slow = s.sy1_slow;
    next_s.sy1_clk  = ext_clock_pins;
    next_s.sy2_clk  = s.sy1_clk;
    next_s.sy1_a    = io_line_a_in;
    next_s.sy2_a    = s.sy1_a;
    next_s.sy1_b    = io_line_b_in;
    next_s.sy2_b    = s.sy1_b;
    next_s.prev_a   = s.sy2_a;
    next_s.prev_b   = s.sy2_b;
    next_s.pre      = s.pre + 7'h01; // RULE8

    // Chain sources: a channel's own output in waveform mode
    for (int k = 0; k < NCH; k++) begin
      a_lvl[k] = s.cmr[k][CMR_WAVE] ? s.a_out[k] : s.sy2_a[k];
    end
    // Each XCn takes its pin or the next channel's io_line_a
    for (int j = 0; j < NCH; j++) begin
      xc[j] = s.bmr[j] ? a_lvl[(j + 1) % NCH] : s.sy2_clk[j]; // RULE7
    end

    // Register read mux
    hit = 1'b1;
    rv  = 32'h0;
    if (blk) begin
      unique case (off)
        OFF_BCR: rv = 32'h0;
        OFF_BMR: rv = {29'h0, s.bmr};
        default: hit = 1'b0;
      endcase
    end else if (paddr[7:6] < 2'(NCH)) begin
      unique case (off)
        OFF_CCR: rv = 32'h0;
        OFF_CMR: rv = {16'h0, s.cmr[ci]};
        OFF_CV:  rv = s.cnt[ci]; // RULE5
        OFF_CPB: rv = s.capb[ci];
        OFF_CMP: rv = s.cmpc[ci];
        OFF_SR: begin
          rv[SR_OVF] = s.ovf[ci];
          rv[SR_CMT] = s.cmt[ci];
          rv[SR_BLD] = s.bld[ci];
          rv[SR_RUN] = s.en[ci]; // RULE15
        end
        default: hit = 1'b0;
      endcase
    end else begin
      hit = 1'b0;
    end

    // One wait state; data and error are taken with pready
    next_s.pready = psel & penable & ~s.pready;
    if (psel & penable & ~s.pready) begin
      next_s.prdata  = pwrite ? 32'h0 : rv;
      next_s.pslverr = ~hit;
    end else begin
      next_s.prdata  = 32'h0;
      next_s.pslverr = 1'b0;
    end
    if (wr & blk & (off == OFF_BMR)) begin
      next_s.bmr = pwdata[2:0];
    end

    // Per-channel counting and clock control
    for (int i = 0; i < NCH; i++) begin
      wave   = s.cmr[i][CMR_WAVE]; // RULE19
      stp    = s.cmr[i][CMR_STOP];
      dis    = s.cmr[i][CMR_DIS];
      gsel   = s.cmr[i][CMR_GATE +: 2];
      ccr_wr = wr & ~blk & (ci == 2'(i)) & (off == OFF_CCR);
      sr_rd  = rd & ~blk & (ci == 2'(i)) & (off == OFF_SR);
      if (wr & ~blk & (ci == 2'(i)) & (off == OFF_CMR)) begin
        next_s.cmr[i] = pwdata[15:0];
      end
      if (wr & ~blk & (ci == 2'(i)) & (off == OFF_CMP)) begin
        next_s.cmpc[i] = pwdata;
      end
      // Select counting clock level
      unique case (s.cmr[i][2:0])
        CS_DIV2:   lvl = s.pre[PRE_DIV2]; // RULE8
        CS_DIV8:   lvl = s.pre[PRE_DIV8];
        CS_DIV32:  lvl = s.pre[PRE_DIV32];
        CS_DIV128: lvl = s.pre[PRE_DIV128];
        CS_SLOW:   lvl = s.sy2_slow;
        CS_EXT0:   lvl = xc[0];
        CS_EXT1:   lvl = xc[1];
        CS_EXT2:   lvl = xc[2];
      endcase
      // Inverting the level turns falling edges into counting edges
      lvl = lvl ^ s.cmr[i][CMR_INVC]; // RULE9
      next_s.prev_lvl[i] = lvl;
      // Burst gate; code zero means no gate
      gate = (gsel == 2'h0) ? 1'b1 : xc[gsel - 2'h1]; // RULE10
      // An edge counts only while enabled and started
      tick[i] = lvl & ~s.prev_lvl[i] & gate & s.en[i] & s.run[i];

      a_rise = s.sy2_a[i] & ~s.prev_a[i];
      b_rise = s.sy2_b[i] & ~s.prev_b[i];
      if (wave) begin
        ext = s.cmr[i][CMR_TSRCB] & b_rise;
      end else begin
        ext = s.cmr[i][CMR_TSRCB] ? b_rise : a_rise;
      end
      ext = ext & s.cmr[i][CMR_ETEN];

      // Capture B loads on a rising io_line_a in capture mode
      bload[i] = ~wave & a_rise;
      if (bload[i]) begin
        next_s.capb[i] = s.cnt[i];
      end
      // Compare C hits when the count steps onto its value
      chit[i] = wave & tick[i] & ~s.pend[i]
                & ((s.cnt[i] + 32'h1) == s.cmpc[i]);

      trig[i] = (ccr_wr & pwdata[CCR_SWTRG])
                | (wr & blk & (off == OFF_BCR) & pwdata[BCR_SYNC]) // RULE2
                | ext
                | (chit[i] & s.cmr[i][CMR_CTRG]);

      // Enable and disable; disable wins when both are written
      if (ccr_wr & pwdata[CCR_DIS]) begin
        next_s.en[i] = 1'b0; // RULE12
      end else if (ccr_wr & pwdata[CCR_EN]) begin
        next_s.en[i] = 1'b1; // RULE12 RULE14
      end
      if (dis & (bload[i] | chit[i])) begin
        next_s.en[i] = 1'b0; // RULE13
      end

      // Start and stop act only while the clock is enabled
      if (s.en[i]) begin // RULE14 RULE18
        if (trig[i]) begin
          next_s.run[i] = 1'b1; // RULE16
        end else if (stp & (bload[i] | chit[i])) begin
          next_s.run[i] = 1'b0; // RULE17
        end
      end

      // A trigger waits for the next counting edge to zero the count
      if (tick[i]) begin
        if (s.pend[i]) begin
          next_s.cnt[i] = 32'h0; // RULE6 RULE22
        end else begin
          next_s.cnt[i] = s.cnt[i] + 32'h1; // RULE3
        end
      end
      next_s.pend[i] = trig[i] | (s.pend[i] & ~tick[i]);

      // Sticky flags clear on status read; a new event wins
      next_s.ovf[i] = (s.ovf[i] & ~sr_rd)
                      | (tick[i] & ~s.pend[i] & (s.cnt[i] == CNT_MAX)); // RULE4
      next_s.cmt[i] = (s.cmt[i] & ~sr_rd) | chit[i];
      next_s.bld[i] = (s.bld[i] & ~sr_rd) | bload[i];
      next_s.irq[i] = next_s.ovf[i] | next_s.cmt[i]
                      | next_s.bld[i]; // RULE1

      // Pin direction follows the new mode at once
      next_s.a_oe[i] = next_s.cmr[i][CMR_WAVE]; // RULE20 RULE21
      next_s.b_oe[i] = next_s.cmr[i][CMR_WAVE]
                       & ~next_s.cmr[i][CMR_TSRCB]; // RULE20 RULE21
      if (chit[i]) begin
        next_s.a_out[i] = ~s.a_out[i];
      end
      if (wave & tick[i] & ~s.pend[i] & (s.cnt[i] == CNT_MAX)) begin
        next_s.b_out[i] = ~s.b_out[i];
      end
    end
  end

  // Single state register; reset clears counters and stops clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0; // RULE23
    end else begin
      s <= next_s;
    end
  end

  // Every output is a flop of the state
  assign prdata        = s.prdata;
  assign pready        = s.pready;
  assign pslverr       = s.pslverr;
  assign io_line_a_out = s.a_out;
  assign io_line_a_oe  = s.a_oe;
  assign io_line_b_out = s.b_out;
  assign io_line_b_oe  = s.b_oe;
  assign channel_irq   = s.irq;

  // Checks on channel 0 and on the APB wait state; the other channels share the same code
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  cnt_step_a: assert property ( // RULE3
    tick[0] && !s.pend[0] |=> s.cnt[0] == $past(s.cnt[0]) + 32'h1)
    else $error("counter did not step by one");

  ovf_wrap_a: assert property ( // RULE4
    tick[0] && !s.pend[0] && s.cnt[0] == CNT_MAX
    |=> s.ovf[0] && s.cnt[0] == 32'h0 && channel_irq[0])
    else $error("wrap did not set overflow");

  trig_zero_a: assert property ( // RULE6
    tick[0] && s.pend[0] |=> s.cnt[0] == 32'h0)
    else $error("pending trigger did not zero count");

  trig_wait_a: assert property ( // RULE22
    trig[0] && !tick[0] ##1 !tick[0] |=> s.pend[0])
    else $error("trigger lost before counting edge");

  dis_hold_a: assert property ( // RULE14
    !s.en[0] |=> $stable(s.cnt[0]) && $stable(s.run[0]))
    else $error("disabled channel changed");

  start_trig_a: assert property ( // RULE16
    s.en[0] && trig[0] |=> s.run[0])
    else $error("trigger did not start clock");

  en_cause_a: assert property ( // RULE12
    $rose(s.en[0]) |-> $past(wr && !blk && ci == 2'h0
      && off == OFF_CCR && pwdata[CCR_EN] && !pwdata[CCR_DIS]))
    else $error("clock enabled without command");

  b_stop_a: assert property ( // RULE17
    s.en[0] && bload[0] && s.cmr[0][CMR_STOP] && !trig[0]
    |=> !s.run[0])
    else $error("b load did not stop clock");

  cap_pins_a: assert property ( // RULE20
    !s.cmr[0][CMR_WAVE] |-> !io_line_a_oe[0] && !io_line_b_oe[0])
    else $error("capture mode drives a pin");

  apb_wait_a: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not one wait state");

endmodule

/* File: tc_pin_model.sv */
// Purpose: Far-side pin model for the timer: clocks, gate and io levels
// Assumes: Driven on pclk edges; external clock levels last 3 cycles
// Notes:   An io line reads the device level only while the device drives
`timescale 1ns/10ps
module tc_pin_model (
  // Clock
  input  wire logic       pclk,
  // Device pin drivers
  input  wire logic [2:0] a_out,
  input  wire logic [2:0] a_oe,
  input  wire logic [2:0] b_out,
  input  wire logic [2:0] b_oe,
  // Levels seen by the device
  output logic            slow_clock,
  output logic [2:0]      ext_clock_pins,
  output logic [2:0]      a_in,
  output logic [2:0]      b_in
);
  logic [2:0] a_lvl;
  logic [2:0] b_lvl;
  logic [5:0] slow_cnt;

  // Idle levels; external clocks stand still outside bursts
  initial begin
    ext_clock_pins = 3'h0;
    a_lvl = 3'h0;
    b_lvl = 3'h0;
    slow_cnt = 6'h00;
    slow_clock = 1'b0;
  end

  // Slow clock runs free, far below pclk
  always @(posedge pclk) begin
    slow_cnt <= slow_cnt + 6'h01;
    slow_clock <= slow_cnt[5];
  end

  // Wire level: device value while driven, model value otherwise
  assign a_in = (a_oe & a_out) | (~a_oe & a_lvl);
  assign b_in = (b_oe & b_out) | (~b_oe & b_lvl);

  // Each level 30 ns, period 60 ns: six times slower than pclk
  task automatic pulse(input int idx, input int k);
    repeat (k) begin
      repeat (3) @(posedge pclk);
      ext_clock_pins[idx] <= 1'b1;
      repeat (3) @(posedge pclk);
      ext_clock_pins[idx] <= 1'b0;
    end
    // Let the synchroniser drain before anyone reads the count
    repeat (6) @(posedge pclk);
  endtask

  // Far-side level on an io_line_a, seen while the device does not drive
  task automatic set_io(input int idx, input logic v);
    @(posedge pclk);
    a_lvl[idx] <= v;
  endtask

  // Static level, used as a gate input
  task automatic set_pin(input int idx, input logic v);
    @(posedge pclk);
    ext_clock_pins[idx] <= v;
  endtask
endmodule

/* File: test_timer_channel_clock_core.sv */
// Purpose: Self-checking bench for the three-channel timer core
// Assumes: APB answer after one wait state; pins from tc_pin_model
// Notes:   Counts use external clock pulses, or DIV2 up to the C match in waveform mode
`timescale 1ns/10ps
module test_timer_channel_clock_core;
  import tc_pkg::*;
  // Bus and pins
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        slow_clock;
  logic [2:0]  ext_clock_pins;
  logic [2:0]  a_in;
  logic [2:0]  b_in;
  logic [2:0]  a_out;
  logic [2:0]  a_oe;
  logic [2:0]  b_out;
  logic [2:0]  b_oe;
  logic [2:0]  channel_irq;
  // Bench state
  int          error_cnt;
  int          comparisons;
  logic [31:0] rdat;
  logic        rerr;

  timer_block timer_block_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .slow_clock(slow_clock),
    .ext_clock_pins(ext_clock_pins), .io_line_a_in(a_in),
    .io_line_b_in(b_in), .io_line_a_out(a_out), .io_line_a_oe(a_oe),
    .io_line_b_out(b_out), .io_line_b_oe(b_oe),
    .channel_irq(channel_irq));

  tc_pin_model pins_i (
    .pclk(pclk), .a_out(a_out), .a_oe(a_oe), .b_out(b_out),
    .b_oe(b_oe), .slow_clock(slow_clock),
    .ext_clock_pins(ext_clock_pins), .a_in(a_in), .b_in(b_in));

  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // One APB transfer; request held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No cycle count assumed; the watchdog bounds a hung slave
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h00000000);
    chk(rdat, exp);
  endtask

  // Mode, gate level, enable plus trigger, pulses, then the count
  task automatic row(input logic [31:0] cmr, input logic g, input int k,
                     input logic [31:0] exp);
    wr(8'h04, cmr);
    pins_i.set_pin(1, g);
    // Enable first: a start only counts once the clock is enabled
    wr(8'h00, 32'h00000001);
    wr(8'h00, 32'h00000004);
    pins_i.pulse(0, k);
    rd(8'h10, exp);
  endtask

  // Bounded wait on the channel 0 interrupt line
  task automatic wait_irq;
    int n;
    n = 0;
    while (channel_irq[0] !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, channel_irq[0]}, 32'h00000001);
  endtask

  task automatic test_done;
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under a tenth of this
  initial begin
    #100000;
    error_cnt++;
    test_done();
  end

  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    error_cnt = 0;
    comparisons = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset state, refused addresses, no counting before enable
    rd(8'h10, 32'h00000000);
    rd(8'h20, 32'h00000000);
    xfer(1'b0, 8'h08, 32'h00000000);
    chk({rdat[30:0], rerr}, 32'h00000001);
    xfer(1'b0, 8'hC8, 32'h00000000);
    chk({rdat[30:0], rerr}, 32'h00000001);
    wr(8'h04, 32'h00000005);
    pins_i.pulse(0, 2);
    rd(8'h10, 32'h00000000);
    // Clock source, inversion and gating on channel 0
    row(32'h00000005, 1'b0, 10, 32'h00000009);
    row(32'h0000000D, 1'b0, 4, 32'h00000003);
    row(32'h00000025, 1'b0, 6, 32'h00000003);
    row(32'h00000025, 1'b1, 2, 32'h00000001);
    // Trigger acts only at the next counting edge
    wr(8'h00, 32'h00000004);
    rd(8'h10, 32'h00000001);
    pins_i.pulse(0, 1);
    rd(8'h10, 32'h00000000);
    // Enable status, disable, and triggers while disabled
    rd(8'h20, 32'h00010000);
    pins_i.pulse(0, 2);
    wr(8'h00, 32'h00000002);
    rd(8'h20, 32'h00000000);
    wr(8'h00, 32'h00000004);
    pins_i.pulse(0, 3);
    rd(8'h10, 32'h00000002);
    rd(8'h20, 32'h00000000);
    chk({26'h0, a_oe, b_oe}, 32'h00000000);
    // Enabled but unstarted channels wait for the block-wide trigger
    wr(8'h44, 32'h00000005);
    wr(8'h84, 32'h00000005);
    wr(8'h40, 32'h00000001);
    wr(8'h80, 32'h00000001);
    pins_i.pulse(0, 3);
    rd(8'h50, 32'h00000000);
    rd(8'h90, 32'h00000000);
    wr(8'hC0, 32'h00000001);
    pins_i.pulse(0, 4);
    rd(8'h50, 32'h00000003);
    rd(8'h90, 32'h00000003);
    rd(8'h10, 32'h00000002);
    wr(8'hC4, 32'h00000007);
    rd(8'hC4, 32'h00000007);
    wr(8'hC4, 32'h00000000);
    // Capture mode: rising io_line_a loads B and stops the clock
    wr(8'h04, 32'h00000045);
    wr(8'h00, 32'h00000001);
    wr(8'h00, 32'h00000004);
    pins_i.pulse(0, 4);
    pins_i.set_io(0, 1'b1);
    pins_i.pulse(0, 2);
    rd(8'h10, 32'h00000003);
    rd(8'h18, 32'h00000003);
    rd(8'h20, 32'h00010040);
    pins_i.set_io(0, 1'b0);
    // Waveform mode: stop, then disable, on the C match
    wr(8'h1C, 32'h00000005);
    rd(8'h1C, 32'h00000005);
    wr(8'h04, 32'h00008040);
    rd(8'h04, 32'h00008040);
    wr(8'h00, 32'h00000005);
    wait_irq();
    rd(8'h10, 32'h00000005);
    chk({29'h0, channel_irq}, 32'h00000001);
    chk({30'h0, a_oe[0], b_oe[0]}, 32'h00000003);
    chk({26'h0, a_out, b_out}, 32'h00000008);
    rd(8'h20, 32'h00010010);
    wr(8'h04, 32'h00008480);
    wr(8'h00, 32'h00000005);
    wait_irq();
    rd(8'h20, 32'h00000010);
    chk({30'h0, a_oe[0], b_oe[0]}, 32'h00000002);
    chk({26'h0, a_out, b_out}, 32'h00000000);
    test_done();
  end
endmodule
